// ---- design/tdw_consts.svh ----
// constants of the timer/watchdog transfer instruction block
`ifndef TDW_CONSTS_SVH
`define TDW_CONSTS_SVH

// -----------------------------------------------------------------
// opcodes (10-bit instruction words)
// -----------------------------------------------------------------
`define TDW_OP_TIMER_THREE  10'h210
`define TDW_OP_TIMER_FOUR   10'h211
`define TDW_OP_ROW_POINTER  10'h00C
`define TDW_OP_WDT_RESTART  10'h2A0
`define TDW_OP_WDT_DISABLE  10'h29C

// -----------------------------------------------------------------
// apb register byte offsets
// -----------------------------------------------------------------
`define TDW_REG_CTRL        12'h000
`define TDW_REG_STATUS      12'h004
`define TDW_REG_WDT         12'h008

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TDW_CTRL_EXEC_EN    0
`define TDW_STAT_W3_LSB     0
`define TDW_STAT_W4_LSB     4
`define TDW_STAT_ROW_LSB    8
`define TDW_STAT_WATCHDOG_FLAG_ONE       12
`define TDW_STAT_WDT_RUN    13
`define TDW_STAT_SKIP       14
`define TDW_WDT_CLR_FLAG    0

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define TDW_RST_CTRL        1'b1
`define TDW_RST_NIBBLE      4'h0
`define TDW_RST_WDT_RUN     1'b1

`endif

// ---- design/tdw_pkg.sv ----
// types shared by the transfer instruction block
package tdw_pkg;
   // index of each decoded instruction
   typedef enum int unsigned {
      TDW_IDX_TIMER_THREE = 0,
      TDW_IDX_TIMER_FOUR  = 1,
      TDW_IDX_ROW_POINTER = 2,
      TDW_IDX_WDT_RESTART = 3,
      TDW_IDX_WDT_DISABLE = 4
   } tdw_op_idx_type;

   localparam int unsigned TDW_NUM_OPS = 5;

   // apb slave phases, one-hot
   typedef enum logic [2:0] {
      TDW_APB_IDLE   = 3'b001,
      TDW_APB_WAIT   = 3'b010,
      TDW_APB_ANSWER = 3'b100
   } tdw_apb_state_type;
endpackage

// ---- design/tdw_opdecode.sv ----
// opcode matcher: one hit line per supported instruction
`include "tdw_consts.svh"
module tdw_opdecode
   import tdw_pkg::*;
#(
   parameter int unsigned CODE_W = 10
) (
   input  wire logic [CODE_W-1:0]      instr_code,
   output logic      [TDW_NUM_OPS-1:0] op_hit
);
   // -----------------------------------------------------------------
   // opcode table
   // -----------------------------------------------------------------
   localparam logic [CODE_W-1:0] OP_TABLE [TDW_NUM_OPS] = '{
      `TDW_OP_TIMER_THREE,
      `TDW_OP_TIMER_FOUR,
      `TDW_OP_ROW_POINTER,
      `TDW_OP_WDT_RESTART,
      `TDW_OP_WDT_DISABLE
   };

   initial begin
      if (CODE_W != 10) begin
         $error("tdw_opdecode: instruction words are 10 bits");
      end
   end

   // -----------------------------------------------------------------
   // full-width compare per table entry
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < TDW_NUM_OPS; g++) begin : g_match
         // all ten bits compared, no don't-care bits
         assign op_hit[g] = (instr_code == OP_TABLE[g]);
      end
   endgenerate
endmodule

// ---- design/tdw_wdt_ctrl.sv ----
// watchdog flag, run state and restart-skip request
`include "tdw_consts.svh"
module tdw_wdt_ctrl (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic exec_stb,
   input  wire logic hit_restart,
   input  wire logic hit_disable,
   input  wire logic flag_set,
   input  wire logic sw_flag_clr,
   output logic      watchdog_flag_one_ff,
   output logic      wdt_run_ff,
   output logic      restart_skip
);
   logic prev_disable_ff;
   logic nxt_watchdog_flag_one;
   logic nxt_wdt_run;
   logic nxt_prev_disable;

   // skip request taken by the core's skip flop in the restart cycle
   assign restart_skip = exec_stb & hit_restart & watchdog_flag_one_ff;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_watchdog_flag_one = watchdog_flag_one_ff;
      nxt_wdt_run           = wdt_run_ff;
      nxt_prev_disable      = prev_disable_ff;
      if ((exec_stb & hit_restart) | sw_flag_clr) begin
         nxt_watchdog_flag_one = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (flag_set) begin
         nxt_watchdog_flag_one = 1'b1;
      end
      if (exec_stb & hit_restart & prev_disable_ff) begin
         nxt_wdt_run = 1'b0;
      end
      // only the instruction directly before counts
      if (exec_stb) begin
         nxt_prev_disable = hit_disable;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         watchdog_flag_one_ff <= 1'b0;
         wdt_run_ff           <= `TDW_RST_WDT_RUN;
         prev_disable_ff      <= 1'b0;
      end else begin
         watchdog_flag_one_ff <= nxt_watchdog_flag_one;
         wdt_run_ff           <= nxt_wdt_run;
         prev_disable_ff      <= nxt_prev_disable;
      end
   end
endmodule

// ---- design/tdw_core.sv ----
// execute logic for timer-control, row-pointer and watchdog restart instructions
//
// Summary of operation
// - the timer-control-three move loads the whole accumulator into that register in one word and one cycle.
// - opcode 10'b1000010001 copies the accumulator into timer control register four in one cycle.
// - opcode 10'b0000001100 copies the accumulator into the row pointer in one word and one cycle.
// - on the restart opcode with the watchdog flag at one, the flag is cleared and the next instruction skipped.
// - on the restart opcode with the watchdog flag at zero, no skip happens and the next instruction runs.
// - a restart executed directly after the watchdog-disable instruction stops the watchdog.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "tdw_consts.svh"
module tdw_core
   import tdw_pkg::*;
#(
   parameter int unsigned CODE_W = 10,
   parameter int unsigned ACC_W  = 4
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // instruction stream from the sequencer, one word per machine cycle
   input  wire logic              instr_valid,
   input  wire logic [CODE_W-1:0] instr_code,
   input  wire logic [ACC_W-1:0]  acc_value,
   input  wire logic              carry_in,
   // watchdog counter reports its first flag
   input  wire logic              wdt_flag_set,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // results towards the core
   output logic      [ACC_W-1:0]  timer_ctrl_reg_three,
   output logic      [ACC_W-1:0]  timer_ctrl_reg_four,
   output logic      [ACC_W-1:0]  row_pointer,
   output logic                   carry_flag,
   output logic                   skip_next,
   output logic                   watchdog_flag_one,
   output logic                   wdt_run
);
   // -----------------------------------------------------------------
   // parameter checks
   // -----------------------------------------------------------------
   // table and fields fix both widths
   if (CODE_W != 10) begin : g_bad_code_w
      $error("tdw_core: instruction words are 10 bits");
   end
   if (ACC_W != 4) begin : g_bad_acc_w
      $error("tdw_core: accumulator is 4 bits");
   end

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   // decode hits and strobes
   logic [TDW_NUM_OPS-1:0] op_hit;
   logic                   exec_stb;
   logic                   restart_skip;
   logic                   sw_flag_clr;
   logic                   apb_wr_take;

   // instruction state
   logic [ACC_W-1:0]       timer_ctrl_reg_three_ff;
   logic [ACC_W-1:0]       timer_ctrl_reg_four_ff;
   logic [ACC_W-1:0]       row_pointer_ff;
   logic                   carry_flag_ff;
   logic                   skip_next_ff;
   logic                   exec_en_ff;

   // next values
   logic [ACC_W-1:0]       nxt_timer_ctrl_reg_three;
   logic [ACC_W-1:0]       nxt_timer_ctrl_reg_four;
   logic [ACC_W-1:0]       nxt_row_pointer;
   logic                   nxt_carry_flag;
   logic                   nxt_skip_next;
   logic                   nxt_exec_en;

   // apb slave state
   tdw_apb_state_type      apb_state_ff;
   tdw_apb_state_type      nxt_apb_state;
   logic [31:0]            prdata_ff;
   logic [31:0]            nxt_prdata;
   logic                   pready_ff;
   logic                   nxt_pready;
   logic                   pslverr_ff;
   logic                   nxt_pslverr;
   logic                   addr_hit;
   logic [31:0]            rd_word;

   // -----------------------------------------------------------------
   // opcode decode
   // -----------------------------------------------------------------
   // pure match; no flop
   tdw_opdecode #(
      .CODE_W     (CODE_W)
   ) u_opdecode (
      .instr_code (instr_code),
      .op_hit     (op_hit)
   );

   // a word in a skip slot is fetched but does nothing
   // exec off: only skip use happens
   assign exec_stb = instr_valid & exec_en_ff & ~skip_next_ff;

   // -----------------------------------------------------------------
   // watchdog flag and run control
   // -----------------------------------------------------------------
   // set-wins flag, stop on restart directly after disable
   tdw_wdt_ctrl u_wdt_ctrl (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .exec_stb             (exec_stb),
      .hit_restart          (op_hit[TDW_IDX_WDT_RESTART]),
      .hit_disable          (op_hit[TDW_IDX_WDT_DISABLE]),
      .flag_set             (wdt_flag_set),
      .sw_flag_clr          (sw_flag_clr),
      .watchdog_flag_one_ff (watchdog_flag_one),
      .wdt_run_ff           (wdt_run),
      .restart_skip         (restart_skip)
   );

   // -----------------------------------------------------------------
   // register transfers
   // -----------------------------------------------------------------
   // each move is a single-word, single-cycle load of the accumulator
   always_comb begin
      // hold unless targeted
      nxt_timer_ctrl_reg_three = timer_ctrl_reg_three_ff;
      nxt_timer_ctrl_reg_four  = timer_ctrl_reg_four_ff;
      nxt_row_pointer          = row_pointer_ff;
      if (exec_stb & op_hit[TDW_IDX_TIMER_THREE]) begin
         nxt_timer_ctrl_reg_three = acc_value;
      end
      if (exec_stb & op_hit[TDW_IDX_TIMER_FOUR]) begin
         nxt_timer_ctrl_reg_four = acc_value;
      end
      if (exec_stb & op_hit[TDW_IDX_ROW_POINTER]) begin
         nxt_row_pointer = acc_value;
      end
   end

   // target registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer_ctrl_reg_three_ff <= `TDW_RST_NIBBLE;
         timer_ctrl_reg_four_ff  <= `TDW_RST_NIBBLE;
         row_pointer_ff          <= `TDW_RST_NIBBLE;
      end else begin
         timer_ctrl_reg_three_ff <= nxt_timer_ctrl_reg_three;
         timer_ctrl_reg_four_ff  <= nxt_timer_ctrl_reg_four;
         row_pointer_ff          <= nxt_row_pointer;
      end
   end

   // -----------------------------------------------------------------
   // carry and skip
   // -----------------------------------------------------------------
   // carry is only mirrored: none of these instructions may change it
   always_comb begin
      nxt_carry_flag = carry_in;
      nxt_skip_next  = skip_next_ff;
      // a skipped word cannot re-arm
      // a pending skip is consumed by the next fetched word
      if (instr_valid & skip_next_ff) begin
         nxt_skip_next = 1'b0;
      end
      // flag at one asks for a skip
      // skip lands on the next fetch
      if (restart_skip) begin
         nxt_skip_next = 1'b1;
      end
   end

   // carry mirror and skip
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         carry_flag_ff <= 1'b0;
         skip_next_ff  <= 1'b0;
      end else begin
         carry_flag_ff <= nxt_carry_flag;
         skip_next_ff  <= nxt_skip_next;
      end
   end

   // -----------------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------------
   // one wait state keeps pready and prdata straight from flops
   // three mapped words
   assign addr_hit    = (paddr == `TDW_REG_CTRL) |
                        (paddr == `TDW_REG_STATUS) |
                        (paddr == `TDW_REG_WDT);
   // writes land at the completing edge only
   assign apb_wr_take = psel & penable & pready_ff & pwrite & addr_hit;
   assign sw_flag_clr = apb_wr_take & (paddr == `TDW_REG_WDT) & pwdata[`TDW_WDT_CLR_FLAG];

   // read mux over the block's own state
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         `TDW_REG_CTRL: begin
            rd_word[`TDW_CTRL_EXEC_EN] = exec_en_ff;
         end
         `TDW_REG_STATUS: begin
            // live state from the wait cycle
            rd_word[`TDW_STAT_W3_LSB +: 4]  = timer_ctrl_reg_three_ff;
            rd_word[`TDW_STAT_W4_LSB +: 4]  = timer_ctrl_reg_four_ff;
            rd_word[`TDW_STAT_ROW_LSB +: 4] = row_pointer_ff;
            rd_word[`TDW_STAT_WATCHDOG_FLAG_ONE]         = watchdog_flag_one;
            rd_word[`TDW_STAT_WDT_RUN]      = wdt_run;
            rd_word[`TDW_STAT_SKIP]         = skip_next_ff;
         end
         `TDW_REG_WDT: begin
            // flag reads where it clears
            rd_word[`TDW_WDT_CLR_FLAG] = watchdog_flag_one;
         end
         default: begin
            // unmapped reads give zero
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // phase machine: idle, wait state, answer
   always_comb begin
      nxt_apb_state = apb_state_ff;
      nxt_pready    = 1'b0;
      nxt_pslverr   = 1'b0;
      nxt_prdata    = prdata_ff;
      nxt_exec_en   = exec_en_ff;
      unique case (apb_state_ff)
         TDW_APB_IDLE: begin
            // setup opens a transfer
            if (psel & ~penable) begin
               nxt_apb_state = TDW_APB_WAIT;
            end
         end
         TDW_APB_WAIT: begin
            // access phase seen: answer on the next edge
            if (psel & penable) begin
               nxt_apb_state = TDW_APB_ANSWER;
               nxt_pready    = 1'b1;
               nxt_pslverr   = ~addr_hit;
               nxt_prdata    = pwrite ? 32'h0000_0000 : rd_word;
            end
         end
         TDW_APB_ANSWER: begin
            // transfer completes here; data cleared for the next one
            nxt_apb_state = (psel & ~penable) ? TDW_APB_WAIT : TDW_APB_IDLE;
            nxt_prdata    = 32'h0000_0000;
            // enable flips at completion
            if (apb_wr_take & (paddr == `TDW_REG_CTRL)) begin
               nxt_exec_en = pwdata[`TDW_CTRL_EXEC_EN];
            end
         end
         default: begin
            // broken one-hot code goes idle
            nxt_apb_state = TDW_APB_IDLE;
         end
      endcase
   end

   // apb phase flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         apb_state_ff <= TDW_APB_IDLE;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
         prdata_ff    <= 32'h0000_0000;
         exec_en_ff   <= `TDW_RST_CTRL;
      end else begin
         apb_state_ff <= nxt_apb_state;
         pready_ff    <= nxt_pready;
         pslverr_ff   <= nxt_pslverr;
         prdata_ff    <= nxt_prdata;
         exec_en_ff   <= nxt_exec_en;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from flops
   // -----------------------------------------------------------------
   assign prdata               = prdata_ff;
   assign pready               = pready_ff;
   assign pslverr              = pslverr_ff;
   assign timer_ctrl_reg_three = timer_ctrl_reg_three_ff;
   assign timer_ctrl_reg_four  = timer_ctrl_reg_four_ff;
   assign row_pointer          = row_pointer_ff;
   assign carry_flag           = carry_flag_ff;
   assign skip_next            = skip_next_ff;
endmodule

// ---- bench/tdw_core_properties.sv ----
// port-level assertions for the transfer instruction block
`include "tdw_consts.svh"
module tdw_core_chk
   import tdw_pkg::*;
#(
   parameter int unsigned CODE_W = 10,
   parameter int unsigned ACC_W  = 4
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              instr_valid,
   input wire logic [CODE_W-1:0] instr_code,
   input wire logic [ACC_W-1:0]  acc_value,
   input wire logic              carry_in,
   input wire logic              wdt_flag_set,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [ACC_W-1:0]  timer_ctrl_reg_three,
   input wire logic              carry_flag,
   input wire logic              skip_next,
   input wire logic              watchdog_flag_one,
   input wire logic              wdt_run
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic en_ff;
   logic take;
   // shadow of the exec enable; a ctrl write lands at the completion edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_ff <= 1'b1;
      end else if (psel && penable && pready && pwrite && paddr == `TDW_REG_CTRL) begin
         en_ff <= pwdata[0];
      end
   end
   assign take = instr_valid && en_ff && !skip_next;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_op(op);
      take && instr_code == op;
   endsequence
   sequence s_apb;
      psel && !penable ##1 psel && penable;
   endsequence
   property p_three;
      s_op(`TDW_OP_TIMER_THREE) |=> timer_ctrl_reg_three == $past(acc_value) && !skip_next;
   endproperty
   a_three: assert property (p_three) else $error("timer three not loaded");
   property p_move_noskip;
      take && (instr_code == `TDW_OP_TIMER_FOUR || instr_code == `TDW_OP_ROW_POINTER) |=> !skip_next;
   endproperty
   a_move_noskip: assert property (p_move_noskip) else $error("move caused skip");
   property p_rst_one;
      s_op(`TDW_OP_WDT_RESTART) ##0 watchdog_flag_one && !wdt_flag_set |=> skip_next && !watchdog_flag_one;
   endproperty
   a_rst_one: assert property (p_rst_one) else $error("restart with flag did not skip");
   property p_rst_zero;
      s_op(`TDW_OP_WDT_RESTART) ##0 !watchdog_flag_one |=> !skip_next;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("restart without flag skipped");
   property p_stop;
      s_op(`TDW_OP_WDT_DISABLE) ##1 s_op(`TDW_OP_WDT_RESTART) |=> !wdt_run;
   endproperty
   a_stop: assert property (p_stop) else $error("watchdog not stopped");
   property p_skip_use;
      instr_valid && en_ff && skip_next |=> !skip_next && $stable(timer_ctrl_reg_three) && $stable(wdt_run);
   endproperty
   a_skip_use: assert property (p_skip_use) else $error("skipped word acted");
   property p_skip_hold;
      skip_next && !instr_valid |=> skip_next;
   endproperty
   a_skip_hold: assert property (p_skip_hold) else $error("skip lost before fetch");
   property p_carry;
      !$past(rst) |-> carry_flag == $past(carry_in);
   endproperty
   a_carry: assert property (p_carry) else $error("carry altered");
   property p_flag_set;
      wdt_flag_set |=> watchdog_flag_one;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_apb;
      s_apb |=> pready && pslverr == !($past(paddr) inside {`TDW_REG_CTRL, `TDW_REG_STATUS, `TDW_REG_WDT});
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer wrong");
   c_skip: cover property (s_op(`TDW_OP_WDT_RESTART) ##1 skip_next);
endmodule

bind tdw_core tdw_core_chk #(.CODE_W(CODE_W), .ACC_W(ACC_W)) i_chk (
   .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_code(instr_code),
   .acc_value(acc_value), .carry_in(carry_in), .wdt_flag_set(wdt_flag_set), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .timer_ctrl_reg_three(timer_ctrl_reg_three), .carry_flag(carry_flag),
   .skip_next(skip_next), .watchdog_flag_one(watchdog_flag_one), .wdt_run(wdt_run));

// ---- bench/timer_wdt_transfer_instrs_test.sv ----
// self-checking bench for the transfer instruction block
`include "tdw_consts.svh"
module timer_wdt_transfer_instrs_test
   import tdw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals and model state
   // ----------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic [9:0]  instr_code = 10'h000;
   logic [3:0]  acc_value = 4'h0;
   logic        carry_in = 1'b0;
   logic        wdt_flag_set = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  w3, w4, row, m_w3, m_w4, m_row;
   logic        carry_flag, skip_next, flag, run, m_flag, m_skip, m_run, m_en, m_prev, m_cy, m_clr;
   logic [31:0] rd, r;
   logic        er;
   int          fails = 0;
   int          tests_run = 0;
   int          seed = 32'ha411_6abf;
   logic [9:0]  ops [5] = '{`TDW_OP_TIMER_THREE, `TDW_OP_TIMER_FOUR, `TDW_OP_ROW_POINTER,
                            `TDW_OP_WDT_RESTART, `TDW_OP_WDT_DISABLE};
   always #20 clk_sys = ~clk_sys;
   tdw_core i_dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_code(instr_code),
      .acc_value(acc_value), .carry_in(carry_in), .wdt_flag_set(wdt_flag_set), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_ctrl_reg_three(w3), .timer_ctrl_reg_four(w4),
      .row_pointer(row), .carry_flag(carry_flag), .skip_next(skip_next),
      .watchdog_flag_one(flag), .wdt_run(run));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // behavioural model, sees inputs as the design samples them
   always @(posedge clk_sys) begin
      if (rst) begin
         {m_w3, m_w4, m_row} = 12'h000;
         {m_flag, m_skip, m_prev, m_cy} = 4'h0;
         {m_run, m_en} = 2'b11;
      end else begin
         m_clr = 1'b0;
         if (psel && penable && pready === 1'b1 && pwrite) begin
            if (paddr == `TDW_REG_CTRL) m_en = pwdata[0];
            if (paddr == `TDW_REG_WDT) m_clr = pwdata[0];
         end
         if (instr_valid && (m_en || m_skip)) begin
            if (m_skip) begin
               m_skip = 1'b0;
            end else begin
               case (instr_code)
                  `TDW_OP_TIMER_THREE: m_w3 = acc_value;
                  `TDW_OP_TIMER_FOUR: m_w4 = acc_value;
                  `TDW_OP_ROW_POINTER: m_row = acc_value;
                  // skip decided from the flag before this edge
                  `TDW_OP_WDT_RESTART: begin
                     m_skip = m_flag;
                     m_clr = 1'b1;
                     if (m_prev) m_run = 1'b0;
                  end
                  default: ;
               endcase
               m_prev = (instr_code == `TDW_OP_WDT_DISABLE);
            end
         end
         // a set in the same cycle as a clear wins
         m_flag = wdt_flag_set | (m_flag & ~m_clr);
         m_cy = carry_in;
      end
   end
   // compare every result where it is settled
   always @(negedge clk_sys) begin
      if (!rst) begin
         chk(32'(w3), 32'(m_w3), "timer three");
         chk(32'(w4), 32'(m_w4), "timer four");
         chk(32'(row), 32'(m_row), "row pointer");
         chk(32'(flag), 32'(m_flag), "watchdog flag");
         chk(32'(skip_next), 32'(m_skip), "skip pending");
         chk(32'(run), 32'(m_run), "watchdog run");
         chk(32'(carry_flag), 32'(m_cy), "carry");
      end
   end
   // one instruction word (or idle) per cycle, back to back
   task automatic word(input logic v, input logic [9:0] c, input logic [3:0] a, input logic f);
      @(posedge clk_sys);
      instr_valid <= v;
      instr_code <= c;
      acc_value <= a;
      wdt_flag_set <= f;
      carry_in <= 1'($random(seed));
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      wdt_flag_set <= 1'b0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(pready), 32'h0000_0001, "apb no answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic status(input string msg);
      apb(1'b0, `TDW_REG_STATUS, 32'h0000_0000);
      chk(rd, {17'h0_0000, m_skip, m_run, m_flag, m_row, m_w4, m_w3}, msg);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      status("status at reset");
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001, "unmapped access");
      $display("done reset");
      for (int i = 0; i < 15; i++) word(1'b1, ops[i % 3], 4'($random(seed)), 1'b0);
      $display("done moves");
      // flag set, restart, skipped move, then a move that runs
      word(1'b0, 10'h000, 4'h0, 1'b1);
      word(1'b1, `TDW_OP_WDT_RESTART, 4'h0, 1'b0);
      word(1'b1, `TDW_OP_TIMER_THREE, 4'hA, 1'b0);
      word(1'b1, `TDW_OP_TIMER_THREE, 4'h5, 1'b0);
      // restart with clear flag does not skip
      word(1'b1, `TDW_OP_WDT_RESTART, 4'h0, 1'b0);
      word(1'b1, `TDW_OP_TIMER_FOUR, 4'h3, 1'b0);
      word(1'b0, 10'h000, 4'h0, 1'b1);
      status("flag before clear");
      apb(1'b1, `TDW_REG_WDT, 32'h0000_0001);
      apb(1'b0, `TDW_REG_WDT, 32'h0000_0000);
      chk(32'(rd[0]), 32'(m_flag), "software flag clear");
      $display("done restart");
      // a word between disable and restart keeps it running
      word(1'b1, `TDW_OP_WDT_DISABLE, 4'h0, 1'b0);
      word(1'b1, `TDW_OP_ROW_POINTER, 4'h7, 1'b0);
      word(1'b1, `TDW_OP_WDT_RESTART, 4'h0, 1'b0);
      word(1'b1, `TDW_OP_WDT_DISABLE, 4'h0, 1'b0);
      word(1'b1, `TDW_OP_WDT_RESTART, 4'h0, 1'b0);
      status("after stop");
      $display("done stop");
      // words ignored while execution is disabled; a pending skip is still used up
      word(1'b0, 10'h000, 4'h0, 1'b1);
      word(1'b1, `TDW_OP_WDT_RESTART, 4'h0, 1'b0);
      apb(1'b1, `TDW_REG_CTRL, 32'h0000_0000);
      word(1'b1, `TDW_OP_TIMER_THREE, 4'hF, 1'b0);
      word(1'b1, `TDW_OP_ROW_POINTER, 4'hF, 1'b0);
      status("exec disabled");
      apb(1'b1, `TDW_REG_CTRL, 32'h0000_0001);
      $display("done enable");
      // random stream of known and unknown words
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         word(r[0] | r[1], r[3] ? r[13:4] : ops[r[22:20] % 5], r[27:24], r[30] & r[31]);
      end
      // reset in mid-run
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      status("second reset");
      $display("done random");
      conclude();
   end
   initial begin
      #800000;
      fails++;
      conclude();
   end
endmodule
